// File: src/gt16_timer.sv
// Gated 16-bit timer/counter with APB registers
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module gt16_timer (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // count and gate pins
  input wire logic count_pin,
  input wire logic gate_pin,
  // oscillator pins
  input wire logic osc_in_pin_i,
  output logic osc_in_pin_o,
  output logic osc_in_pin_oe,
  input wire logic osc_out_pin_i,
  output logic osc_out_pin_o,
  output logic osc_out_pin_oe,
  // system state
  input wire logic sleep,
  input wire logic primary_clk_ok,
  // events and status
  output logic irq,
  output logic wake,
  output logic timebase_ok
);
  // ******************************************************
  // registers and bus
  // ******************************************************
  logic [gt16_pkg::CTRL_W-1:0] ctrl;
  logic [15:0] cnt;
  logic ovf;
  logic mask_ovf;
  logic dir_in, dir_out, lat_in, lat_out;
  logic [31:0] next_prdata;
  logic next_err;
  logic wr, cnt_wr, clr_ovf;

  assign pready = psel & penable;
  assign wr = psel & penable & pwrite;
  assign cnt_wr = wr & ((paddr == gt16_pkg::A_CNT_LO) |
                        (paddr == gt16_pkg::A_CNT_HI));
  assign clr_ovf = wr & (paddr == gt16_pkg::A_STAT) &
                   pwdata[gt16_pkg::B_OVF];

  // ******************************************************
  // pin synchronisers and derived modes
  // ******************************************************
  logic [gt16_pkg::SY_W-1:0] sy1, sy2;
  logic ext_lvl, ext_prev, rise, fall;
  logic ext_mode, async_mode, sync_ext, osc_active;
  logic gate_act, count_en, awake_ok;
  logic [1:0] div_q;
  logic div4_en, int_en;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sy1 <= '0;
      sy2 <= '0;
    end else begin
      sy1 <= {osc_out_pin_i, gate_pin, osc_in_pin_i, count_pin};
      sy2 <= sy1;
    end
  end

  assign osc_active = ctrl[gt16_pkg::B_OSCEN] & primary_clk_ok;
  // the crystal feeds the counter in place of the count pin
  assign ext_lvl = osc_active ? sy2[gt16_pkg::SY_OSC]
                              : sy2[gt16_pkg::SY_CNT];
  assign rise = ext_lvl & ~ext_prev;
  assign fall = ~ext_lvl & ext_prev;
  assign ext_mode = ctrl[gt16_pkg::B_SRC];
  assign async_mode = ext_mode & ctrl[gt16_pkg::B_NOSYNC];
  assign sync_ext = ext_mode & ~ctrl[gt16_pkg::B_NOSYNC];
  assign gate_act = ctrl[gt16_pkg::B_GATE_INV] ? sy2[gt16_pkg::SY_GATE]
                                               : ~sy2[gt16_pkg::SY_GATE];
  assign count_en = ctrl[gt16_pkg::B_RUN] &
                    (~ctrl[gt16_pkg::B_GATE_EN] | gate_act);
  assign awake_ok = ~sleep | async_mode;
  assign div4_en = (div_q == gt16_pkg::DIV4_LAST);
  assign int_en = ctrl[gt16_pkg::B_ALT] | div4_en;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_prev <= 1'h0;
      div_q <= 2'h0;
    end else begin
      ext_prev <= ext_lvl;
      div_q <= div_q + 2'h1;
    end
  end

  // ******************************************************
  // first falling edge guard
  // ******************************************************
  logic need_fall, run_d, pin_at_stop;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      run_d <= 1'h0;
      pin_at_stop <= 1'h0;
    end else begin
      run_d <= ctrl[gt16_pkg::B_RUN];
      if (run_d & ~ctrl[gt16_pkg::B_RUN]) begin
        pin_at_stop <= ext_lvl;
      end
    end
  end

  // reset value covers the first enable after power-up
  always_ff @(posedge clk) begin
    if (!nrst) begin
      need_fall <= 1'h1;
    end else if (cnt_wr) begin
      need_fall <= 1'h1;
    end else if (~run_d & ctrl[gt16_pkg::B_RUN] & pin_at_stop &
                 ~ext_lvl) begin
      need_fall <= 1'h1;
    end else if (fall & ctrl[gt16_pkg::B_RUN] & ext_mode) begin
      need_fall <= 1'h0;
    end
  end

  // ******************************************************
  // prescaler, sync stage and counter
  // ******************************************************
  gt16_psc_if psc_if ();
  logic d1, d2, inc, ovf_evt;

  assign psc_if.tick = count_en & awake_ok &
                       (ext_mode ? (rise & ~need_fall) : int_en);
  assign psc_if.clr = cnt_wr;
  assign psc_if.field = ctrl[gt16_pkg::B_PSC +: 2];

  gt16_prescale u_psc (
    .clk(clk),
    .nrst(nrst),
    .p(psc_if.psc)
  );

  // a pulse caught in the sync stage at a mode switch may be dropped
  // or counted twice; this is accepted rather than paying for a guard
  always_ff @(posedge clk) begin
    if (!nrst) begin
      d1 <= 1'h0;
      d2 <= 1'h0;
    end else begin
      d1 <= psc_if.out & ~cnt_wr;
      d2 <= d1 & ~cnt_wr;
    end
  end

  assign inc = sync_ext ? d2 : psc_if.out;
  assign ovf_evt = inc & ~cnt_wr & (cnt == gt16_pkg::CNT_MAX);

  // a byte write wins over a coinciding increment
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt <= 16'h0000;
    end else if (wr & (paddr == gt16_pkg::A_CNT_LO)) begin
      cnt[7:0] <= pwdata[7:0];
    end else if (wr & (paddr == gt16_pkg::A_CNT_HI)) begin
      cnt[15:8] <= pwdata[7:0];
    end else if (inc) begin
      cnt <= cnt + 16'h0001;
    end
  end

  // ******************************************************
  // control, status and pin registers
  // ******************************************************
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl <= gt16_pkg::CTRL_RST;
      mask_ovf <= 1'h0;
    end else if (wr & (paddr == gt16_pkg::A_CTRL)) begin
      ctrl <= pwdata[gt16_pkg::CTRL_W-1:0];
    end else if (wr & (paddr == gt16_pkg::A_MASK)) begin
      mask_ovf <= pwdata[gt16_pkg::B_OVF];
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ovf <= 1'h0;
    end else begin
      ovf <= (ovf & ~clr_ovf) | ovf_evt;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dir_in <= gt16_pkg::DIR_RST;
      dir_out <= gt16_pkg::DIR_RST;
      lat_in <= gt16_pkg::LAT_RST;
      lat_out <= gt16_pkg::LAT_RST;
    end else if (osc_active) begin
      dir_in <= 1'h1;
      dir_out <= 1'h1;
    end else if (wr & (paddr == gt16_pkg::A_PINS)) begin
      dir_in <= pwdata[gt16_pkg::B_DIR_IN];
      dir_out <= pwdata[gt16_pkg::B_DIR_OUT];
      lat_in <= pwdata[gt16_pkg::B_LAT_IN];
      lat_out <= pwdata[gt16_pkg::B_LAT_OUT];
    end
  end

  // inverting amplifier model: the out pin mirrors the inverted input
  assign osc_in_pin_o = lat_in;
  assign osc_in_pin_oe = ~dir_in & ~osc_active;
  assign osc_out_pin_o = osc_active ? ~sy2[gt16_pkg::SY_OSC] : lat_out;
  assign osc_out_pin_oe = osc_active | ~dir_out;

  assign irq = ovf & mask_ovf;
  assign wake = irq & sleep;
  assign timebase_ok = ~async_mode &
                       ~(~ext_mode & ctrl[gt16_pkg::B_ALT]);

  // ******************************************************
  // read path: captured in the setup cycle
  // ******************************************************
  always_comb begin
    next_prdata = 32'h0000_0000;
    next_err = 1'h0;
    if (paddr == gt16_pkg::A_CTRL) begin
      next_prdata[gt16_pkg::CTRL_W-1:0] = ctrl;
    end else if (paddr == gt16_pkg::A_CNT_LO) begin
      next_prdata[7:0] = cnt[7:0];
    end else if (paddr == gt16_pkg::A_CNT_HI) begin
      next_prdata[7:0] = cnt[15:8];
    end else if (paddr == gt16_pkg::A_STAT) begin
      next_prdata[gt16_pkg::B_OVF] = ovf;
    end else if (paddr == gt16_pkg::A_MASK) begin
      next_prdata[gt16_pkg::B_OVF] = mask_ovf;
    end else if (paddr == gt16_pkg::A_PINS) begin
      next_prdata[gt16_pkg::B_DIR_IN] = dir_in | osc_active;
      next_prdata[gt16_pkg::B_DIR_OUT] = dir_out | osc_active;
      next_prdata[gt16_pkg::B_PORT_IN] =
        sy2[gt16_pkg::SY_OSC] & ~osc_active;
      next_prdata[gt16_pkg::B_PORT_OUT] =
        sy2[gt16_pkg::SY_OUT] & ~osc_active;
      next_prdata[gt16_pkg::B_LAT_IN] = lat_in;
      next_prdata[gt16_pkg::B_LAT_OUT] = lat_out;
    end else if (paddr == gt16_pkg::A_INFO) begin
      next_prdata[gt16_pkg::B_TB_OK] = timebase_ok;
      next_prdata[gt16_pkg::B_NEED_FALL] = need_fall;
    end else begin
      next_err = 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'h0;
    end else if (psel & ~penable) begin
      prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_err;
    end
  end

  // ******************************************************
  // checks
  // ******************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_cnt_inc;
    inc & ~cnt_wr |=> cnt == 16'($past(cnt) + 16'h0001);
  endproperty
  a_cnt_inc: assert property (p_cnt_inc)
    else $error("counter did not advance by one");
  property p_wr_lo;
    wr & (paddr == gt16_pkg::A_CNT_LO) |=> cnt[7:0] == $past(pwdata[7:0]);
  endproperty
  a_wr_lo: assert property (p_wr_lo)
    else $error("low byte write not loaded");
  property p_fosc4;
    psc_if.tick & ~ext_mode |-> ctrl[gt16_pkg::B_ALT] | div4_en;
  endproperty
  a_fosc4: assert property (p_fosc4)
    else $error("internal tick off the quarter rate");
  property p_ext_rise;
    psc_if.tick & ext_mode |-> rise & ~need_fall & $past(~ext_lvl);
  endproperty
  a_ext_rise: assert property (p_ext_rise)
    else $error("external tick without armed rising edge");
  property p_div1;
    psc_if.tick & ~cnt_wr & (psc_if.field == gt16_pkg::PSC_DIV1)
      |-> psc_if.out;
  endproperty
  a_div1: assert property (p_div1)
    else $error("divide by one swallowed a tick");
  property p_ovf;
    ovf_evt |=> ovf & (cnt == 16'h0000);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("rollover did not set overflow");
  property p_gate;
    psc_if.tick |-> ctrl[gt16_pkg::B_RUN] &
      (~ctrl[gt16_pkg::B_GATE_EN] | gate_act);
  endproperty
  a_gate: assert property (p_gate)
    else $error("tick while stopped or gated off");
  property p_sync;
    (sync_ext & psc_if.out & ~cnt_wr) ##1 (sync_ext & ~cnt_wr) ##1 sync_ext
      |-> inc;
  endproperty
  a_sync: assert property (p_sync)
    else $error("synced pulse not counted two cycles later");
  property p_wr_arm;
    cnt_wr |=> need_fall & ~(ext_mode & psc_if.out);
  endproperty
  a_wr_arm: assert property (p_wr_arm)
    else $error("count write did not rearm falling edge guard");
  property p_sleep;
    sleep & ~async_mode |-> ~psc_if.tick;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("counting in sleep outside async mode");
  property p_tb;
    async_mode |-> ~timebase_ok;
  endproperty
  a_tb: assert property (p_tb)
    else $error("time base offered in async mode");
  property p_osc_dir;
    osc_active |=> dir_in & dir_out;
  endproperty
  a_osc_dir: assert property (p_osc_dir)
    else $error("oscillator pins not set as inputs");

  c_ovf: cover property (ovf_evt);
  c_async_sleep: cover property (async_mode & sleep & inc);
  c_guard: cover property (need_fall & fall & ext_mode);
  c_irq: cover property (irq ##1 clr_ovf);
endmodule : gt16_timer

// File: include/gt16_pkg.sv
// Constants, register map and helpers for the gated 16-bit timer/counter
//
// Summary of operation
// - 16-bit up counter seen as low and high byte; byte writes load at once.
// - clock: internal Fosc/4, internal Fosc when alt set, else count pin.
// - internal source: one count per clock tick times the prescale ratio.
// - external mode counts rising edges of the count pin after the prescaler.
// - no_sync set counts without the sync stage; clear adds it.
// - falling edge needed first: after reset, count write, high-stop/low-start.
// - prescaler divides the selected clock by 1, 2, 4 or 8.
// - prescale counter hidden from software; cleared by any count byte write.
// - low-power crystal oscillator on two pins, on by osc_enable, runs asleep.
// - oscillator usable only with internal or low-power primary clock.
// - oscillator on: pin direction bits set, read 1; port bits read 0.
// - asynchronous mode keeps counting in sleep; overflow can wake.
// - sync/async switch may drop or add a single count.
// - no capture/compare time base in async mode or internal alt clock.
// - rollover from all ones to zero sets overflow flag; software clears.
// - prescale field 00 /1, 01 /2, 10 /4, 11 /8.
// - run set: count while gate active if gate_enable, else always.
package gt16_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CNT_LO = 8'h04;
  localparam logic [7:0] A_CNT_HI = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0C;
  localparam logic [7:0] A_MASK = 8'h10;
  localparam logic [7:0] A_PINS = 8'h14;
  localparam int A_INFO_DUMMY = 0;
  localparam logic [7:0] A_INFO = 8'h18;
  // control register layout
  localparam int CTRL_W = 9;
  localparam logic [8:0] CTRL_RST = 9'h000;
  localparam int B_RUN = 0;
  localparam int B_SRC = 1;
  localparam int B_NOSYNC = 2;
  localparam int B_OSCEN = 3;
  localparam int B_PSC = 4;
  localparam int B_GATE_EN = 6;
  localparam int B_GATE_INV = 7;
  localparam int B_ALT = 8;
  // pin control register layout
  localparam int B_DIR_IN = 0;
  localparam int B_DIR_OUT = 1;
  localparam int B_PORT_IN = 2;
  localparam int B_PORT_OUT = 3;
  localparam int B_LAT_IN = 4;
  localparam int B_LAT_OUT = 5;
  localparam logic DIR_RST = 1'h1;
  localparam logic LAT_RST = 1'h0;
  // status, mask and info layout
  localparam int B_OVF = 0;
  localparam int B_TB_OK = 0;
  localparam int B_NEED_FALL = 1;
  // synchroniser lanes
  localparam int SY_W = 4;
  localparam int SY_CNT = 0;
  localparam int SY_OSC = 1;
  localparam int SY_GATE = 2;
  localparam int SY_OUT = 3;
  // prescale codes and internal clock divider
  localparam logic [1:0] PSC_DIV1 = 2'h0;
  localparam logic [1:0] PSC_DIV2 = 2'h1;
  localparam logic [1:0] PSC_DIV4 = 2'h2;
  localparam logic [1:0] PSC_DIV8 = 2'h3;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  // last prescale count before an output pulse
  function automatic logic [2:0] psc_last(input logic [1:0] f);
    case (f)
      PSC_DIV1: psc_last = 3'h0;
      PSC_DIV2: psc_last = 3'h1;
      PSC_DIV4: psc_last = 3'h3;
      default: psc_last = 3'h7;
    endcase
  endfunction : psc_last
endpackage : gt16_pkg

// File: include/gt16_psc_if.sv
// Connection between the timer core and its prescaler
`timescale 1ns/1ns
interface gt16_psc_if;
  logic tick;
  logic clr;
  logic [1:0] field;
  logic out;
  modport ctl (output tick, output clr, output field, input out);
  modport psc (input tick, input clr, input field, output out);
endinterface : gt16_psc_if

// File: src/gt16_prescale.sv
// Prescaler: divides count ticks by 1, 2, 4 or 8
`timescale 1ns/1ns
module gt16_prescale (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // core side
  gt16_psc_if.psc p
);
  logic [2:0] cnt;
  logic [2:0] last;

  assign last = gt16_pkg::psc_last(p.field);
  // >= so that a smaller ratio chosen mid-count never overruns
  assign p.out = p.tick & ~p.clr & (cnt >= last);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt <= 3'h0;
    end else if (p.clr) begin
      cnt <= 3'h0;
    end else if (p.tick) begin
      cnt <= (cnt >= last) ? 3'h0 : cnt + 3'h1;
    end
  end

  property p_psc_clr;
    @(posedge clk) disable iff (!nrst) p.clr |=> cnt == 3'h0;
  endproperty
  a_psc_clr: assert property (p_psc_clr)
    else $error("prescale counter not cleared by count write");
endmodule : gt16_prescale

// File: sim/gt16_count_src.sv
// Behavioural count source: pulse generator or low-power crystal
`timescale 1ns/1ns
module gt16_count_src (
  // pacing clock
  input wire logic clk,
  // source lines
  output logic pin,
  output logic xtal
);
  // ****************************************
  // burst generator
  // ****************************************
  // both lines rest low between bursts; neither source runs free
  initial begin
    pin = 1'b0;
    xtal = 1'b0;
  end

  // n periods, high then low for half clocks each; large half is slow
  task automatic pulses(input logic use_xtal, input int n, input int half);
    for (int i = 0; i < n; i++) begin
      if (use_xtal) begin
        xtal <= 1'b1;
      end else begin
        pin <= 1'b1;
      end
      repeat (half) @(posedge clk);
      pin <= 1'b0;
      xtal <= 1'b0;
      repeat (half) @(posedge clk);
    end
  endtask : pulses
endmodule : gt16_count_src

// File: sim/gt16_timer_tb.sv
// Self-checking testbench for the gated 16-bit timer/counter
`timescale 1ns/1ns
module gt16_timer_tb;
  // ****************************************
  // signals and instances
  // ****************************************
  logic clk, nrst, psel, penable, pwrite, gate_pin, sleep, primary_clk_ok;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic pready, pslverr, irq, wake, timebase_ok, count_pin, xtal, err_v;
  logic osc_in_pin_i, osc_in_pin_o, osc_in_pin_oe;
  logic osc_out_pin_i, osc_out_pin_o, osc_out_pin_oe;
  int num_errors = 0;
  int compares = 0;

  // a driving end wins; else the crystal, else the line is pulled low
  assign osc_in_pin_i = osc_in_pin_oe ? osc_in_pin_o : xtal;
  assign osc_out_pin_i = osc_out_pin_oe ? osc_out_pin_o : 1'b0;

  gt16_timer u_gt16_timer (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_pin(count_pin), .gate_pin(gate_pin),
    .osc_in_pin_i(osc_in_pin_i), .osc_in_pin_o(osc_in_pin_o),
    .osc_in_pin_oe(osc_in_pin_oe), .osc_out_pin_i(osc_out_pin_i),
    .osc_out_pin_o(osc_out_pin_o), .osc_out_pin_oe(osc_out_pin_oe),
    .sleep(sleep), .primary_clk_ok(primary_clk_ok), .irq(irq),
    .wake(wake), .timebase_ok(timebase_ok));

  gt16_count_src u_gt16_count_src (.clk(clk), .pin(count_pin),
    .xtal(xtal));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // counts may be one off because of divider phase
  task automatic near(input logic [31:0] seen, input int e);
    check({31'h0, seen >= e - 1 && seen <= e + 1}, 32'h1);
  endtask : near

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) begin
      num_errors++;
    end
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic load(input logic [15:0] v);
    wr(gt16_pkg::A_CNT_LO, {24'h0, v[7:0]});
    wr(gt16_pkg::A_CNT_HI, {24'h0, v[15:8]});
  endtask : load

  task automatic rdcnt;
    logic [7:0] lo;
    rd(gt16_pkg::A_CNT_LO);
    lo = rd_v[7:0];
    rd(gt16_pkg::A_CNT_HI);
    rd_v = {16'h0, rd_v[7:0], lo};
  endtask : rdcnt

  // run the timer for w idle cycles between start and stop writes
  task automatic run_for(input logic [31:0] c, input int w);
    wr(gt16_pkg::A_CTRL, c);
    repeat (w) @(posedge clk);
    wr(gt16_pkg::A_CTRL, 32'h0);
    rdcnt();
  endtask : run_for

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd(gt16_pkg::A_CTRL);
    check(rd_v, 32'h0);
    rd(gt16_pkg::A_PINS);
    check(rd_v, 32'h3);
    rd(gt16_pkg::A_INFO);
    check(rd_v, 32'h3);
    rd(8'h1C);
    check({err_v, rd_v[30:0]}, 32'h80000000);
    wr(8'h1C, 32'hFF);
    check({31'h0, err_v}, 32'h1);
  endtask : t_reset

  task automatic t_rate;
    for (int p = 0; p < 4; p++) begin
      load(16'h0);
      run_for({26'h0, p[1:0], 4'h1}, 80 * (1 << p) - 2);
      near(rd_v, 20);
    end
    load(16'h0);
    wr(gt16_pkg::A_CTRL, 32'h101);
    repeat (8) @(posedge clk);
    check({31'h0, timebase_ok}, 32'h0);
    // stop first: a load into a live counter is overtaken by new counts
    wr(gt16_pkg::A_CTRL, 32'h0);
    load(16'h0);
    run_for(32'h101, 38);
    near(rd_v, 40);
    load(16'h0);
    sleep <= 1'b1;
    run_for(32'h101, 20);
    sleep <= 1'b0;
    check(rd_v, 32'h0);
  endtask : t_rate

  task automatic t_ovf;
    load(16'hA5C3);
    rdcnt();
    check(rd_v, 32'hA5C3);
    wr(gt16_pkg::A_MASK, 32'h1);
    load(16'hFFFE);
    run_for(32'h101, 6);
    rd(gt16_pkg::A_STAT);
    check(rd_v, 32'h1);
    check({31'h0, irq}, 32'h1);
    wr(gt16_pkg::A_MASK, 32'h0);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    wr(gt16_pkg::A_MASK, 32'h1);
    wr(gt16_pkg::A_STAT, 32'h1);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
  endtask : t_ovf

  task automatic t_ext;
    load(16'h0);
    wr(gt16_pkg::A_CTRL, 32'h13);
    u_gt16_count_src.pulses(1'b0, 9, 3);
    repeat (10) @(posedge clk);
    rdcnt();
    check(rd_v, 32'h4);
    wr(gt16_pkg::A_CTRL, 32'h07);
    u_gt16_count_src.pulses(1'b0, 4, 2);
    repeat (10) @(posedge clk);
    rdcnt();
    near(rd_v, 8);
    check({31'h0, timebase_ok}, 32'h0);
    load(16'hFFFE);
    sleep <= 1'b1;
    u_gt16_count_src.pulses(1'b0, 3, 3);
    repeat (10) @(posedge clk);
    check({31'h0, wake}, 32'h1);
    sleep <= 1'b0;
    wr(gt16_pkg::A_CTRL, 32'h0);
    rdcnt();
    check(rd_v, 32'h0);
    wr(gt16_pkg::A_STAT, 32'h1);
    // pin high at stop and low at restart must rearm the guard
    wr(gt16_pkg::A_CTRL, 32'h07);
    u_gt16_count_src.pin <= 1'b1;
    repeat (4) @(posedge clk);
    wr(gt16_pkg::A_CTRL, 32'h0);
    u_gt16_count_src.pin <= 1'b0;
    repeat (4) @(posedge clk);
    wr(gt16_pkg::A_CTRL, 32'h07);
    @(posedge clk);
    rd(gt16_pkg::A_INFO);
    check(rd_v, 32'h2);
    wr(gt16_pkg::A_CTRL, 32'h0);
  endtask : t_ext

  task automatic t_gate;
    load(16'h0);
    run_for(32'h1C1, 30);
    check(rd_v, 32'h0);
    load(16'h0);
    run_for(32'h141, 30);
    near(rd_v, 32);
  endtask : t_gate

  task automatic t_osc;
    primary_clk_ok <= 1'b0;
    wr(gt16_pkg::A_PINS, 32'h30);
    wr(gt16_pkg::A_CTRL, 32'h08);
    rd(gt16_pkg::A_PINS);
    check(rd_v, 32'h3C);
    check({31'h0, osc_in_pin_oe}, 32'h1);
    check({31'h0, osc_in_pin_o}, 32'h1);
    check({31'h0, osc_out_pin_o}, 32'h1);
    primary_clk_ok <= 1'b1;
    // start-up wait before the timer may run on the crystal
    repeat (8) @(posedge clk);
    rd(gt16_pkg::A_PINS);
    check(rd_v, 32'h33);
    check({31'h0, osc_out_pin_oe}, 32'h1);
    check({31'h0, osc_in_pin_oe}, 32'h0);
    check({31'h0, osc_out_pin_o}, 32'h1);
    load(16'h0);
    wr(gt16_pkg::A_CTRL, 32'h0F);
    u_gt16_count_src.pulses(1'b1, 3, 4);
    repeat (10) @(posedge clk);
    rdcnt();
    check(rd_v, 32'h2);
  endtask : t_osc

  task automatic report_and_stop;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    gate_pin = 1'b0;
    sleep = 1'b0;
    primary_clk_ok = 1'b1;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_rate();
    t_ovf();
    t_ext();
    t_gate();
    t_osc();
    report_and_stop();
  end

  // the whole run needs far fewer than 50000 cycles
  initial begin
    #200000;
    num_errors++;
    report_and_stop();
  end
endmodule : gt16_timer_tb
